// ===== core/bal_pkg.sv
// constants and types shared by the byte add and logic execution block
package bal_pkg;
   // opcode fields (upper bits of the 16-bit instruction word)
   localparam logic [7:0] OP_ADD_LIT  = 8'h0F;
   localparam logic [7:0] OP_AND_LIT  = 8'h0B;
   localparam logic [5:0] OP_ADD_REG  = 6'h09;
   localparam logic [5:0] OP_ADDC_REG = 6'h08;
   localparam logic [5:0] OP_AND_REG  = 6'h05;
   localparam int         DEST_BIT    = 9;
   localparam int         BANK_BIT    = 8;
   // access bank split: low half of page 0, upper half of page 15
   localparam logic [7:0] ACC_SPLIT   = 8'h80;
   localparam logic [3:0] ACC_HI_PAGE = 4'hF;
   localparam logic [3:0] ACC_LO_PAGE = 4'h0;
   localparam logic [7:0] ACC_RST     = 8'h00;
   localparam logic [4:0] FLAG_RST    = 5'h00;
   // status flag positions
   localparam int FLG_C  = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z  = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N  = 4;

   typedef enum logic [3:0] {
      PH_DECODE  = 4'h1,
      PH_READ    = 4'h2,
      PH_PROCESS = 4'h4,
      PH_WRITE   = 4'h8
   } bal_phase_t;

   typedef enum logic [2:0] {
      K_NONE = 3'h0,
      K_ADDL = 3'h1,
      K_ADDR = 3'h2,
      K_ADDC = 3'h3,
      K_ANDL = 3'h4,
      K_ANDR = 3'h5
   } bal_kind_t;
endpackage : bal_pkg

// ===== core/bal_alu_if.sv
// carrier between the executor and its arithmetic unit
`timescale 1ns/1ns
interface bal_alu_if;
   import bal_pkg::*;
   bal_kind_t  kind;
   logic [7:0] a;
   logic [7:0] b;
   logic       cin;
   logic [7:0] res;
   logic       c;
   logic       dc;
   logic       ov;
   logic       arith;
   modport ctl (output kind, output a, output b, output cin,
                input res, input c, input dc, input ov, input arith);
   modport alu (input kind, input a, input b, input cin,
                output res, output c, output dc, output ov, output arith);
endinterface : bal_alu_if

// ===== core/bal_alu.sv
// combinational add and and unit with carry, nibble carry and signed wrap
`timescale 1ns/1ns
module bal_alu
   import bal_pkg::*;
(
   bal_alu_if.alu p
);
   logic [4:0] lo;
   logic [4:0] hi;
   logic       ci;

   always_comb begin
      ci = (p.kind == K_ADDC) ? p.cin : 1'b0;
      lo = {1'b0, p.a[3:0]} + {1'b0, p.b[3:0]} + {4'h0, ci};
      hi = {1'b0, p.a[7:4]} + {1'b0, p.b[7:4]} + {4'h0, lo[4]};
      p.arith = (p.kind == K_ADDL) || (p.kind == K_ADDR) || (p.kind == K_ADDC);
      if (p.arith) begin
         p.res = {hi[3:0], lo[3:0]};
         p.c   = hi[4];
         p.dc  = lo[4];
         p.ov  = (p.a[7] == p.b[7]) && (hi[3] != p.a[7]);
      end else begin
         p.res = p.a & p.b;
         p.c   = 1'b0;
         p.dc  = 1'b0;
         p.ov  = 1'b0;
      end
   end
endmodule : bal_alu

// ===== core/bal_exec.sv
// execution datapath for byte add and and instructions
// Operation
// - register-add opcode adds accumulator and register, updating N OV C DC Z
// - add-with-carry sums accumulator, register and carry, updating all five flags
// - register-and forms accumulator AND register, updating only N and Z
// - literal-and writes accumulator AND literal to accumulator, N and Z only
// - for register ops, destination bit 0 writes accumulator, 1 writes the register back
// - bank bit 0 resolves the address inside the fixed access bank
// - bank bit 1 forms the address from bank pointer and address field
// - register-and stores back to the register when destination bit is one
`timescale 1ns/1ns
module bal_exec
   import bal_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr,
   input  wire logic [3:0]  bank_select_pointer,
   input  wire logic [7:0]  mem_rdata,
   output logic             instr_ready,
   output logic [11:0]      mem_addr,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic [7:0]       mem_wdata,
   output logic [7:0]       working_accumulator,
   output logic             neg_flag,
   output logic             signed_wrap_flag,
   output logic             carry_flag,
   output logic             nibble_carry_flag,
   output logic             zero_flag,
   output logic             illegal_op,
   output logic             done
);
   bal_phase_t  phase_r;
   bal_kind_t   kind_r;
   logic [7:0]  lit_r;
   logic        dest_r;
   logic [7:0]  opnd_r;
   logic [7:0]  res_r;
   logic [4:0]  alu_flg_r;
   logic [4:0]  flags_r;
   logic [11:0] addr_r;
   bal_kind_t   kind_nxt;
   logic [11:0] addr_nxt;
   logic [7:0]  sum_view;
   logic        dec_reg_op;
   logic        cur_reg_op;
   logic        cur_lit_op;
   logic        store_back;

   bal_alu_if alu_bus ();
   bal_alu u_alu (.p(alu_bus));

   // decode of the instruction word
   always_comb begin
      kind_nxt = K_NONE;
      if (instr[15:8] == OP_ADD_LIT)        kind_nxt = K_ADDL;
      else if (instr[15:8] == OP_AND_LIT)   kind_nxt = K_ANDL;
      else if (instr[15:10] == OP_ADD_REG)  kind_nxt = K_ADDR;
      else if (instr[15:10] == OP_ADDC_REG) kind_nxt = K_ADDC;
      else if (instr[15:10] == OP_AND_REG)  kind_nxt = K_ANDR;
   end

   // operand source and write-back steering
   always_comb begin
      dec_reg_op = (kind_nxt == K_ADDR) || (kind_nxt == K_ADDC) || (kind_nxt == K_ANDR);
      cur_reg_op = (kind_r == K_ADDR) || (kind_r == K_ADDC) || (kind_r == K_ANDR);
      cur_lit_op = (kind_r == K_ADDL) || (kind_r == K_ANDL);
      store_back = dest_r && cur_reg_op;
   end

   // address resolution
   always_comb begin
      if (!instr[BANK_BIT]) begin
         // access bank
         addr_nxt = {(instr[7:0] < ACC_SPLIT) ? ACC_LO_PAGE : ACC_HI_PAGE,
                     instr[7:0]};
      end else begin
         addr_nxt = {bank_select_pointer, instr[7:0]};
      end
   end

   always_comb begin
      alu_bus.kind = kind_r;
      alu_bus.a    = working_accumulator;
      alu_bus.b    = opnd_r;
      alu_bus.cin  = flags_r[FLG_C];
   end

   // four phase sequencer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase_r <= PH_DECODE;
      end else begin
         unique case (phase_r)
            PH_DECODE:  if (instr_valid) phase_r <= PH_READ;
            PH_READ:    phase_r <= PH_PROCESS;
            PH_PROCESS: phase_r <= PH_WRITE;
            PH_WRITE:   phase_r <= PH_DECODE;
            default:    phase_r <= PH_DECODE;
         endcase
      end
   end

   // latch decoded fields
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         kind_r <= K_NONE;
         lit_r  <= ACC_RST;
         dest_r <= 1'b0;
         addr_r <= 12'h000;
      end else if (phase_r == PH_DECODE && instr_valid) begin
         kind_r <= kind_nxt;
         lit_r  <= instr[7:0];
         dest_r <= instr[DEST_BIT];
         addr_r <= addr_nxt;
      end
   end

   // operand read
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         opnd_r <= ACC_RST;
      end else if (phase_r == PH_READ) begin
         if (cur_lit_op) opnd_r <= lit_r;
         else opnd_r <= mem_rdata;
      end
   end

   // process: capture result and flag candidates
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         res_r     <= ACC_RST;
         alu_flg_r <= FLAG_RST;
      end else if (phase_r == PH_PROCESS) begin
         res_r <= alu_bus.res;
         alu_flg_r[FLG_C]  <= alu_bus.c;
         alu_flg_r[FLG_DC] <= alu_bus.dc;
         alu_flg_r[FLG_OV] <= alu_bus.ov;
         alu_flg_r[FLG_Z]  <= (alu_bus.res == 8'h00);
         alu_flg_r[FLG_N]  <= alu_bus.res[7];
      end
   end

   assign sum_view = res_r;

   // write to destination: accumulator
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         working_accumulator <= ACC_RST;
      end else if (phase_r == PH_WRITE && kind_r != K_NONE) begin
         if (!store_back)
            working_accumulator <= sum_view;
      end
   end

   // status flags: logic ops touch only N and Z
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags_r <= FLAG_RST;
      end else if (phase_r == PH_WRITE && kind_r != K_NONE) begin
         flags_r[FLG_N] <= alu_flg_r[FLG_N];
         flags_r[FLG_Z] <= alu_flg_r[FLG_Z];
         if (alu_bus.arith) begin
            flags_r[FLG_C]  <= alu_flg_r[FLG_C];
            flags_r[FLG_DC] <= alu_flg_r[FLG_DC];
            flags_r[FLG_OV] <= alu_flg_r[FLG_OV];
         end
      end
   end

   // memory port, all registered
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mem_addr  <= 12'h000;
         mem_rd    <= 1'b0;
         mem_wr    <= 1'b0;
         mem_wdata <= 8'h00;
      end else begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         if (phase_r == PH_DECODE && instr_valid) begin
            mem_addr <= addr_nxt;
            mem_rd   <= dec_reg_op;
         end
         if (phase_r == PH_PROCESS) begin
            mem_addr  <= addr_r;
            mem_wdata <= alu_bus.res;
            mem_wr    <= store_back;
         end
      end
   end

   // handshake hint
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         instr_ready <= 1'b0;
      end else begin
         instr_ready <= (phase_r == PH_WRITE) ||
                        (phase_r == PH_DECODE && !instr_valid);
      end
   end

   // completion pulses: a refused word pulses illegal_op in place of done
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         illegal_op <= 1'b0;
         done       <= 1'b0;
      end else begin
         done       <= (phase_r == PH_WRITE) && (kind_r != K_NONE);
         illegal_op <= (phase_r == PH_WRITE) && (kind_r == K_NONE);
      end
   end

   always_comb begin
      neg_flag          = flags_r[FLG_N];
      signed_wrap_flag  = flags_r[FLG_OV];
      carry_flag        = flags_r[FLG_C];
      nibble_carry_flag = flags_r[FLG_DC];
      zero_flag         = flags_r[FLG_Z];
   end
endmodule : bal_exec

// ===== testbench/bal_exec_props.sv
// port-level timing checks for the execution block
`timescale 1ns/1ns
module bal_exec_props (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       instr_valid,
   input wire logic [11:0] mem_addr,
   input wire logic       mem_rd,
   input wire logic       mem_wr,
   input wire logic [7:0] working_accumulator,
   input wire logic       neg_flag,
   input wire logic       signed_wrap_flag,
   input wire logic       carry_flag,
   input wire logic       nibble_carry_flag,
   input wire logic       zero_flag,
   input wire logic       illegal_op,
   input wire logic       done
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_done_spacing: assert property (done |=> !done [*3])
      else $error("done pulses closer than four cycles");
   a_read_to_done: assert property (mem_rd |-> ##3 done)
      else $error("done not three cycles after read");
   a_write_to_done: assert property (mem_wr |=> done)
      else $error("done not right after write");
   a_read_cause: assert property (mem_rd |-> $past(instr_valid))
      else $error("read without a taken instruction");
   a_addr_hold: assert property (mem_rd |=> $stable(mem_addr) [*3])
      else $error("address moved during instruction");
   a_acc_by_done: assert property ($changed(working_accumulator) |-> done)
      else $error("accumulator changed without done");
   a_flags_by_done: assert property ($changed({neg_flag, signed_wrap_flag, carry_flag,
      nibble_carry_flag, zero_flag}) |-> done)
      else $error("flags changed without done");
   a_store_keeps_acc: assert property (mem_wr |=> $stable(working_accumulator))
      else $error("accumulator changed on register store");
   a_refuse_quiet: assert property (illegal_op |-> !done && $stable(working_accumulator))
      else $error("refused opcode changed state");
endmodule : bal_exec_props

// ===== testbench/tb.sv
// self-checking bench for the byte add and logic execution block
`timescale 1ns/1ns
module tb;
   import bal_pkg::*;
   logic        clk, rstn, instr_valid, mem_rd, mem_wr, instr_ready, illegal_op, done;
   logic        neg_flag, signed_wrap_flag, carry_flag, nibble_carry_flag, zero_flag;
   logic [15:0] instr;
   logic [3:0]  bank_select_pointer;
   logic [7:0]  mem_rdata, mem_wdata, working_accumulator, acc_m;
   logic [11:0] mem_addr;
   logic [4:0]  flg_m;
   int          errors = 0, samples_checked = 0, cycles = 0;

   bal_exec DUT (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
      .bank_select_pointer(bank_select_pointer), .mem_rdata(mem_rdata),
      .instr_ready(instr_ready), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .working_accumulator(working_accumulator),
      .neg_flag(neg_flag), .signed_wrap_flag(signed_wrap_flag), .carry_flag(carry_flag),
      .nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag),
      .illegal_op(illegal_op), .done(done));

   task automatic summarize;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // issue one word, watch the memory side and compare with the reference
   task automatic run(input logic [15:0] w, input logic [3:0] bp, input logic [7:0] rd);
      logic [8:0] s;
      logic [7:0] b, r, gw;
      logic [11:0] ea, ga;
      logic reg_op, is_add, ill, ci, dc, ov, seen_rd, seen_wr, wb;
      int n;
      reg_op = w[15:10] inside {OP_ADD_REG, OP_ADDC_REG, OP_AND_REG};
      is_add = w[15:8] == OP_ADD_LIT || w[15:10] == OP_ADD_REG || w[15:10] == OP_ADDC_REG;
      ill = !reg_op && w[15:8] != OP_ADD_LIT && w[15:8] != OP_AND_LIT;
      wb = reg_op && w[DEST_BIT];
      b = reg_op ? rd : w[7:0];
      ci = (w[15:10] == OP_ADDC_REG) ? flg_m[FLG_C] : 1'b0;
      ea = w[BANK_BIT] ? {bp, w[7:0]} : {(w[7:0] < ACC_SPLIT) ? ACC_LO_PAGE : ACC_HI_PAGE, w[7:0]};
      s = {1'b0, acc_m} + {1'b0, b} + {8'h00, ci};
      dc = ({1'b0, acc_m[3:0]} + {1'b0, b[3:0]} + {4'h0, ci}) > 5'h0F;
      ov = acc_m[7] == b[7] && s[7] != acc_m[7];
      r = is_add ? s[7:0] : acc_m & b;
      @(posedge clk);
      instr <= w;
      bank_select_pointer <= bp;
      mem_rdata <= rd;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      seen_rd = 1'b0;
      seen_wr = 1'b0;
      n = 0;
      while (!done && !illegal_op && n < 8) begin
         @(negedge clk);
         n++;
         if (mem_rd) begin
            seen_rd = 1'b1;
            ga = mem_addr;
         end
         if (mem_wr) begin
            seen_wr = 1'b1;
            gw = mem_wdata;
         end
      end
      chk(16'(n), 16'h0004);
      chk(done, !ill);
      chk(instr_ready, 1'b1);
      if (ill) chk(illegal_op, 1'b1);
      else begin
         chk(illegal_op, 1'b0);
         chk(seen_rd, reg_op);
         if (reg_op) chk(ga, ea);
         chk(seen_wr, wb);
         if (seen_wr) chk(gw, r);
         if (!wb) acc_m = r;
         flg_m[FLG_Z] = r == 8'h00;
         flg_m[FLG_N] = r[7];
         if (is_add) flg_m[FLG_C] = s[8];
         if (is_add) flg_m[FLG_DC] = dc;
         if (is_add) flg_m[FLG_OV] = ov;
      end
      chk(working_accumulator, acc_m);
      chk({neg_flag, signed_wrap_flag, zero_flag, nibble_carry_flag, carry_flag},
          flg_m);
   endtask : run

   task automatic t_lit_add;
      run(16'h0F10, 4'h0, 8'h00);
      run(16'h0F15, 4'h0, 8'h00);
      run(16'h0F5B, 4'h0, 8'h00);
      run(16'h0F80, 4'h0, 8'h00);
   endtask : t_lit_add

   task automatic t_reg_add;
      run(16'h2134, 4'h5, 8'h02);
      run(16'h0F14, 4'h0, 8'h00);
      run(16'h2420, 4'hA, 8'hC2);
      run(16'h2690, 4'h3, 8'h47);
      run(16'h23FF, 4'h9, 8'hFF);
   endtask : t_reg_add

   task automatic t_logic;
      run(16'h17A5, 4'hC, 8'h3C);
      run(16'h1410, 4'h0, 8'hF0);
      run(16'h0B5F, 4'h0, 8'h00);
      run(16'h0B00, 4'h0, 8'h00);
   endtask : t_logic

   task automatic t_refuse;
      run(16'hFFFF, 4'h0, 8'h11);
      run(16'h0000, 4'h0, 8'h11);
   endtask : t_refuse

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         errors++;
         summarize();
      end
   end

   initial begin
      rstn = 1'b0;
      instr_valid = 1'b0;
      instr = 16'h0000;
      bank_select_pointer = 4'h0;
      mem_rdata = 8'h00;
      acc_m = ACC_RST;
      flg_m = FLAG_RST;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      chk(working_accumulator, ACC_RST);
      t_lit_add();
      t_reg_add();
      t_logic();
      t_refuse();
      summarize();
   end
endmodule : tb

bind bal_exec bal_exec_props u_props (.clk(clk), .rstn(rstn), .instr_valid(instr_valid),
   .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
   .working_accumulator(working_accumulator), .neg_flag(neg_flag),
   .signed_wrap_flag(signed_wrap_flag), .carry_flag(carry_flag),
   .nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag),
   .illegal_op(illegal_op), .done(done));
